// >>> brf_pkg.sv
// package: address map, field positions and types of the register file
package brf_pkg;
  // address map
  localparam logic [7:0] BRF_PORT_ZERO = 8'h00;
  localparam logic [7:0] BRF_PORT_ONE = 8'h01;
  localparam logic [7:0] BRF_PORT_TWO = 8'h02;
  localparam logic [7:0] BRF_PORT_THREE = 8'h03;
  localparam logic [7:0] BRF_GP_LOW = 8'h04;
  localparam logic [7:0] BRF_GP_HIGH = 8'hEF;
  localparam logic [7:0] BRF_PROT_LOW = 8'h80;
  localparam logic [7:0] BRF_CTRL_LOW = 8'hF0;
  localparam logic [7:0] BRF_SERIAL_IO_DATA = 8'hF0;
  localparam logic [7:0] BRF_TIMER_MODE = 8'hF1;
  localparam logic [7:0] BRF_TIMER_ONE_COUNT = 8'hF2;
  localparam logic [7:0] BRF_TIMER_ONE_PRESCALER = 8'hF3;
  localparam logic [7:0] BRF_TIMER_ZERO_COUNT = 8'hF4;
  localparam logic [7:0] BRF_TIMER_ZERO_PRESCALER = 8'hF5;
  localparam logic [7:0] BRF_PORT_TWO_DIRECTION_MODE = 8'hF6;
  localparam logic [7:0] BRF_PORT_THREE_FUNCTION_MODE = 8'hF7;
  localparam logic [7:0] BRF_PORT_ZERO_ONE_MODE = 8'hF8;
  localparam logic [7:0] BRF_INTERRUPT_PRIORITY = 8'hF9;
  localparam logic [7:0] BRF_INTERRUPT_REQUEST = 8'hFA;
  localparam logic [7:0] BRF_INTERRUPT_MASK = 8'hFB;
  localparam logic [7:0] BRF_PROGRAM_FLAGS = 8'hFC;
  localparam logic [7:0] BRF_WORKING_GROUP_POINTER = 8'hFD;
  localparam logic [7:0] BRF_STACK_POINTER_HIGH = 8'hFE;
  localparam logic [7:0] BRF_STACK_POINTER_LOW = 8'hFF;
  // nibble that marks a working-register reference in an 8-bit field
  localparam logic [3:0] BRF_WORK_ESCAPE = 4'hE;
  // field positions
  localparam int BRF_PROTECT_ENABLE_BIT = 6;
  // read value of write-only locations
  localparam logic [7:0] BRF_WO_READ = 8'hFF;
  // control register and port latch reset values, standard bank number
  localparam logic [7:0] BRF_CTRL_RESET = 8'h00;
  localparam logic [7:0] BRF_ALL_ONES = 8'hFF;
  localparam logic [3:0] BRF_STD_BANK = 4'h0;

  // request from the execution unit
  typedef struct packed {
    logic valid;     // one-cycle access request
    logic write;     // 1 write, 0 read
    logic word;      // 16-bit pair access
    logic short_adr; // 4-bit working-register address
    logic [7:0] adr; // 8-bit address or 4-bit field in [3:0]
    logic [15:0] wdata; // word: msb in [15:8]; byte in [7:0]
  } brf_req_t;

  // answer to the execution unit
  typedef struct packed {
    logic valid;      // answer strobe
    logic blocked;    // access refused by protection
    logic [7:0] padr; // physical address used
    logic [15:0] rdata; // word: even byte in [15:8]
  } brf_rsp_t;
endpackage : brf_pkg

// >>> brf_regfile.sv
// module: byte register file with working-group and pair addressing
`timescale 1ns/100ps
`default_nettype none
module brf_regfile #(
  parameter bit PROTECT_OPTION = 1'b1, // build-time protection option
  parameter bit HAS_UPPER = 1'b1,      // memory at 80h and above exists
  parameter int BANK_COUNT = 16        // banks addressable by pointer
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  // access port from the execution unit
  input wire brf_pkg::brf_req_t req,
  input wire logic load_pointer,        // dedicated pointer load
  input wire logic [7:0] load_pointer_value,
  output brf_pkg::brf_rsp_t rsp,
  // port pins and alternate functions
  input wire logic [7:0] port_pin_in [4],
  input wire logic [7:0] port_alt_out_mask [4], // alternate-driven bits
  input wire logic [7:0] port_adr_out_mask [2], // address-output bits
  output logic [7:0] port_latch_out [4],
  // control state to the rest of the core
  output logic [7:0] pointer_out,
  output logic protect_active
);
  import brf_pkg::*;

  // general bytes, no reset so contents persist
  logic [7:0] gp_mem [256];
  // bank registers standing in for 00h-0Fh
  logic [7:0] bank_mem [BANK_COUNT*16];
  // control registers F0h-FFh
  logic [7:0] ctrl_r [16];
  // port output latches
  logic [7:0] port_r [4];
  // pin synchronisers
  logic [7:0] pin_s1_r [4];
  logic [7:0] pin_s2_r [4];
  // answer register
  brf_rsp_t rsp_r;

  // physical address, protection and word decoding
  logic [7:0] padr_even;
  logic [7:0] padr_odd;
  logic prot_hit;
  logic [3:0] bank_sel;

  // map any request to a physical address
  function automatic logic [7:0] brf_phys(input logic short_adr,
                                          input logic [7:0] adr,
                                          input logic [7:0] ptr);
    if (short_adr) begin
      brf_phys = {ptr[7:4], adr[3:0]};
    end else if (adr[7:4] == BRF_WORK_ESCAPE) begin
      brf_phys = {ptr[7:4], adr[3:0]};
    end else begin
      brf_phys = adr;
    end
  endfunction

  // is this address in the protected upper area
  function automatic logic brf_in_prot(input logic [7:0] a);
    brf_in_prot = (a >= BRF_PROT_LOW) && (a <= BRF_GP_HIGH);
  endfunction

  // is this a general byte that no selected bank hides
  function automatic logic brf_gp_hit(input logic [7:0] a,
                                      input logic [3:0] bank);
    brf_gp_hit = (a > BRF_PORT_THREE) && (a < BRF_CTRL_LOW)
      && !(bank != BRF_STD_BANK && a[7:4] == 4'h0);
  endfunction

  // read one physical byte as software sees it
  function automatic logic [7:0] brf_peek(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a >= BRF_CTRL_LOW) begin
      unique case (a)
        BRF_TIMER_ONE_PRESCALER, BRF_TIMER_ZERO_PRESCALER,
        BRF_PORT_TWO_DIRECTION_MODE, BRF_PORT_THREE_FUNCTION_MODE,
        BRF_PORT_ZERO_ONE_MODE, BRF_INTERRUPT_PRIORITY: begin
          v = BRF_WO_READ;
        end
        BRF_WORKING_GROUP_POINTER: begin
          v = ctrl_r[4'hD];
        end
        default: begin
          v = ctrl_r[a[3:0]];
        end
      endcase
    end else if (bank_sel != BRF_STD_BANK && a[7:4] == 4'h0) begin
      v = bank_mem[{bank_sel, a[3:0]}];
    end else if (a <= BRF_PORT_THREE) begin
      v = pin_s2_r[a[1:0]];
      if (a == BRF_PORT_ZERO || a == BRF_PORT_ONE) begin
        v = v | port_adr_out_mask[a[0]];
      end
    end else begin
      v = gp_mem[a];
    end
    return v;
  endfunction

  // address decode of the current request
  always_comb begin
    bank_sel = ctrl_r[4'hD][3:0];
    padr_even = brf_phys(req.short_adr, req.adr, ctrl_r[4'hD]);
    if (req.word) begin
      padr_even = {padr_even[7:1], 1'b0};
    end
    padr_odd = {padr_even[7:1], 1'b1};
    // protection exists only with the option and the memory behind it
    prot_hit = PROTECT_OPTION && HAS_UPPER
      && ctrl_r[4'hB][BRF_PROTECT_ENABLE_BIT]
      && (brf_in_prot(padr_even) || (req.word && brf_in_prot(padr_odd)));
  end

  // two-flop synchronisers on the port pins
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int p = 0; p < 4; p++) begin
        pin_s1_r[p] <= 8'h00;
        pin_s2_r[p] <= 8'h00;
      end
    end else if (clk_en) begin
      for (int p = 0; p < 4; p++) begin
        pin_s1_r[p] <= port_pin_in[p];
        pin_s2_r[p] <= pin_s1_r[p];
      end
    end
  end

  // general storage, no reset
  always_ff @(posedge clk_sys) begin
    if (clk_en && req.valid && req.write && !prot_hit) begin
      if (req.word) begin
        if (brf_gp_hit(padr_even, bank_sel)) begin
          gp_mem[padr_even] <= req.wdata[15:8];
        end
        if (brf_gp_hit(padr_odd, bank_sel)) begin
          gp_mem[padr_odd] <= req.wdata[7:0];
        end
      end else if (brf_gp_hit(padr_even, bank_sel)) begin
        gp_mem[padr_even] <= req.wdata[7:0];
      end
    end
  end

  // bank registers, no reset
  always_ff @(posedge clk_sys) begin
    if (clk_en && req.valid && req.write && bank_sel != BRF_STD_BANK
        && padr_even[7:4] == 4'h0) begin
      if (req.word) begin
        bank_mem[{bank_sel, padr_even[3:0]}] <= req.wdata[15:8];
        bank_mem[{bank_sel, padr_odd[3:0]}] <= req.wdata[7:0];
      end else begin
        bank_mem[{bank_sel, padr_even[3:0]}] <= req.wdata[7:0];
      end
    end
  end

  // control registers and port latches
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 16; i++) begin
        ctrl_r[i] <= BRF_CTRL_RESET;
      end
      for (int p = 0; p < 4; p++) begin
        port_r[p] <= BRF_ALL_ONES;
      end
    end else if (clk_en) begin
      if (load_pointer) begin
        ctrl_r[4'hD] <= load_pointer_value;
      end else if (req.valid && req.write) begin
        // control area and ports are never protected
        if (padr_even >= BRF_CTRL_LOW) begin
          ctrl_r[padr_even[3:0]] <= req.word ? req.wdata[15:8]
                                             : req.wdata[7:0];
          if (req.word) begin
            ctrl_r[padr_odd[3:0]] <= req.wdata[7:0];
          end
        end else if (padr_even <= BRF_PORT_THREE
                     && !(bank_sel != BRF_STD_BANK)) begin
          for (int p = 0; p < 4; p++) begin
            if (p[1:0] == padr_even[1:0] ||
                (req.word && p[1:0] == padr_odd[1:0])) begin
              port_r[p] <= (port_r[p] & port_alt_out_mask[p]) |
                ((req.word && p[1:0] == padr_even[1:0] ? req.wdata[15:8]
                                                       : req.wdata[7:0])
                 & ~port_alt_out_mask[p]);
            end
          end
        end
      end
    end
  end

  // registered answer, one cycle after the request
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rsp_r <= '0;
    end else if (clk_en) begin
      rsp_r.valid <= req.valid;
      rsp_r.blocked <= req.valid && prot_hit;
      rsp_r.padr <= padr_even;
      if (!req.valid || req.write) begin
        rsp_r.rdata <= rsp_r.rdata;
      end else if (prot_hit) begin
        rsp_r.rdata <= 16'h0000;
      end else if (req.word) begin
        rsp_r.rdata <= {brf_peek(padr_even), brf_peek(padr_odd)};
      end else begin
        rsp_r.rdata <= {8'h00, brf_peek(padr_even)};
      end
    end
  end

  // outputs straight from flops
  assign rsp = rsp_r;
  assign pointer_out = ctrl_r[4'hD];
  assign port_latch_out = port_r;

  // protection state flop for the core
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      protect_active <= 1'b0;
    end else if (clk_en) begin
      protect_active <= PROTECT_OPTION && HAS_UPPER &&
        ctrl_r[4'hB][BRF_PROTECT_ENABLE_BIT];
    end
  end

  // assertions
  property p_wo_read;
    @(posedge clk_sys) disable iff (!reset_n)
    (clk_en && req.valid && !req.write && !req.word && !req.short_adr
     && (req.adr == BRF_TIMER_ONE_PRESCALER
         || req.adr == BRF_INTERRUPT_PRIORITY))
    |=> rsp.rdata[7:0] == BRF_WO_READ;
  endproperty
  a_wo_read: assert property (p_wo_read)
    else $error("wo read not FFh");

  property p_protect;
    @(posedge clk_sys) disable iff (!reset_n)
    (clk_en && req.valid && prot_hit) |=> rsp.blocked;
  endproperty
  a_protect: assert property (p_protect)
    else $error("protect missed");

  property p_short_map;
    @(posedge clk_sys) disable iff (!reset_n)
    (clk_en && req.valid && req.short_adr && !req.word) |=>
    rsp.padr == {$past(ctrl_r[4'hD][7:4]), $past(req.adr[3:0])};
  endproperty
  a_short_map: assert property (p_short_map)
    else $error("short map bad");

  property p_direct;
    @(posedge clk_sys) disable iff (!reset_n)
    (clk_en && req.valid && !req.short_adr && !req.word &&
     req.adr[7:4] != BRF_WORK_ESCAPE) |=> rsp.padr == $past(req.adr);
  endproperty
  a_direct: assert property (p_direct)
    else $error("direct addr bad");

  property p_word_even;
    @(posedge clk_sys) disable iff (!reset_n)
    (clk_en && req.valid && req.word) |=> rsp.padr[0] == 1'b0;
  endproperty
  a_word_even: assert property (p_word_even)
    else $error("word odd");

  property p_load_ptr;
    @(posedge clk_sys) disable iff (!reset_n)
    (clk_en && load_pointer) |=> pointer_out == $past(load_pointer_value);
  endproperty
  a_load_ptr: assert property (p_load_ptr)
    else $error("pointer load");

  property p_no_prot_opt;
    @(posedge clk_sys) disable iff (!reset_n)
    (clk_en && req.valid && !(PROTECT_OPTION && HAS_UPPER))
    |=> !rsp.blocked;
  endproperty
  a_no_prot_opt: assert property (p_no_prot_opt)
    else $error("prot opt");

  property p_ptr_read;
    @(posedge clk_sys) disable iff (!reset_n)
    (clk_en && req.valid && !req.write && !req.word && !req.short_adr
     && req.adr == BRF_WORKING_GROUP_POINTER)
    |=> rsp.rdata[3:0] == $past(ctrl_r[4'hD][3:0]);
  endproperty
  a_ptr_read: assert property (p_ptr_read)
    else $error("pointer read");

  // direct access to the upper area is refused while the bit is set
  property p_protect_area;
    @(posedge clk_sys) disable iff (!reset_n)
    (clk_en && req.valid && !req.short_adr && !req.word
     && req.adr[7:4] inside {[4'h8:4'hD]}
     && ctrl_r[4'hB][BRF_PROTECT_ENABLE_BIT])
    |=> rsp.blocked == (PROTECT_OPTION && HAS_UPPER);
  endproperty
  a_protect_area: assert property (p_protect_area)
    else $error("upper area not refused");

  // a refused write leaves the general byte as it was
  property p_gp_blocked;
    @(posedge clk_sys) disable iff (!reset_n)
    (clk_en && req.valid && req.write && !req.word && !req.short_adr
     && req.adr[7:4] inside {[4'h8:4'hD]} && PROTECT_OPTION && HAS_UPPER
     && ctrl_r[4'hB][BRF_PROTECT_ENABLE_BIT])
    |=> gp_mem[$past(req.adr)] == $past(gp_mem[req.adr]);
  endproperty
  a_gp_blocked: assert property (p_gp_blocked)
    else $error("refused write landed");

  // word write puts the msb at the even byte
  property p_even_msb;
    @(posedge clk_sys) disable iff (!reset_n)
    (clk_en && req.valid && req.write && req.word && !req.short_adr
     && req.adr[7:4] inside {[4'h1:4'h7]})
    |=> gp_mem[{$past(req.adr[7:1]), 1'b0}] == $past(req.wdata[15:8])
        && gp_mem[{$past(req.adr[7:1]), 1'b1}] == $past(req.wdata[7:0]);
  endproperty
  a_even_msb: assert property (p_even_msb)
    else $error("word pair order bad");

  // low sixteen writes land in the selected bank
  property p_bank;
    @(posedge clk_sys) disable iff (!reset_n)
    (clk_en && req.valid && req.write && !req.word && !req.short_adr
     && req.adr[7:4] == 4'h0 && ctrl_r[4'hD][3:0] != BRF_STD_BANK)
    |=> bank_mem[{$past(ctrl_r[4'hD][3:0]), $past(req.adr[3:0])}]
        == $past(req.wdata[7:0]);
  endproperty
  a_bank: assert property (p_bank)
    else $error("bank write missed");

  // address-output bits of port zero read as ones
  property p_port_ones;
    @(posedge clk_sys) disable iff (!reset_n)
    (clk_en && req.valid && !req.write && !req.word && !req.short_adr
     && req.adr == BRF_PORT_ZERO && ctrl_r[4'hD][3:0] == BRF_STD_BANK)
    |=> (rsp.rdata[7:0] & $past(port_adr_out_mask[0]))
        == $past(port_adr_out_mask[0]);
  endproperty
  a_port_ones: assert property (p_port_ones)
    else $error("address bits not ones");

  // alternate-owned latch bits survive a port write
  property p_alt_keep;
    @(posedge clk_sys) disable iff (!reset_n)
    (clk_en && req.valid && req.write && !req.word && !req.short_adr
     && req.adr == BRF_PORT_TWO && ctrl_r[4'hD][3:0] == BRF_STD_BANK)
    |=> ((port_latch_out[2] ^ $past(port_latch_out[2]))
         & $past(port_alt_out_mask[2])) == 8'h00;
  endproperty
  a_alt_keep: assert property (p_alt_keep)
    else $error("alternate bit written");

  // escape nibble in an 8-bit field goes through the pointer
  property p_escape;
    @(posedge clk_sys) disable iff (!reset_n)
    (clk_en && req.valid && !req.short_adr && !req.word
     && req.adr[7:4] == BRF_WORK_ESCAPE) |=>
    rsp.padr == {$past(ctrl_r[4'hD][7:4]), $past(req.adr[3:0])};
  endproperty
  a_escape: assert property (p_escape)
    else $error("escape map bad");

  c_word: cover property (@(posedge clk_sys) req.valid && req.word);
  c_block: cover property (@(posedge clk_sys) rsp.blocked);
  c_short: cover property (@(posedge clk_sys) req.valid && req.short_adr);
  c_bank: cover property (@(posedge clk_sys)
    req.valid && bank_sel != BRF_STD_BANK);
  c_load: cover property (@(posedge clk_sys) load_pointer);
endmodule : brf_regfile
`default_nettype wire

// >>> brf_core_model.sv
// execution unit model that issues accesses to the register file
`timescale 1ns/100ps
`default_nettype none
module brf_core_model (
  // clock
  input wire logic clk_sys,
  // access port towards the register file
  output var brf_pkg::brf_req_t req,
  output var logic load_pointer,
  output var logic [7:0] load_pointer_value,
  input wire brf_pkg::brf_rsp_t rsp
);
  import brf_pkg::*;
  brf_rsp_t last; // answer of the latest access

  // idle values at time zero
  initial begin
    req = '0;
    load_pointer = 1'b0;
    load_pointer_value = 8'h00;
    last = '0;
  end

  // one access: raised after a falling edge, held over the taking edge
  task automatic access(input logic wr, input logic wd, input logic sh,
    input logic [7:0] a, input logic [15:0] d);
    int n;
    @(negedge clk_sys);
    req = {1'b1, wr, wd, sh, a, d};
    @(posedge clk_sys);
    n = 0;
    @(negedge clk_sys);
    // released qualifiers are inverted so stale values never look valid
    req = {1'b0, ~wr, ~wd, ~sh, ~a, ~d};
    // answer awaited for a bounded number of cycles
    while (rsp.valid !== 1'b1 && n < 4) begin
      @(negedge clk_sys);
      n++;
    end
    last = rsp;
  endtask

  // dedicated pointer load command, one cycle long
  task automatic load_ptr(input logic [7:0] v);
    @(negedge clk_sys);
    load_pointer = 1'b1;
    load_pointer_value = v;
    @(negedge clk_sys);
    load_pointer = 1'b0;
    load_pointer_value = ~v;
  endtask
endmodule // brf_core_model
`default_nettype wire

// >>> byte_register_file_decode_tb.sv
// self-checking testbench of the byte register file
`timescale 1ns/100ps
`default_nettype none
module byte_register_file_decode_tb;
  import brf_pkg::*;
  logic clk_sys; // core clock
  logic reset_n; // async reset
  logic clk_en; // state freeze, held on
  brf_req_t req; // request from the model
  brf_rsp_t rsp; // answer to the model
  logic load_pointer; // pointer load strobe
  logic [7:0] load_pointer_value; // pointer load value
  logic [7:0] pin_in [4]; // port pins
  logic [7:0] alt_mask [4]; // alternate-owned bits
  logic [7:0] adr_mask [2]; // address-output bits
  logic [7:0] latch_out [4]; // port latches
  logic [7:0] pointer_out; // pointer to the core
  logic protect_active; // protection state
  int n_errors; // mismatches
  int num_checks; // comparisons
  logic wo; // write-only location flag
  logic [7:0] exp_v; // expected control read
  brf_rsp_t rsp_off; // answer of the build without protection
  logic protect_off; // protection state of that build

  // design under test
  brf_regfile dut (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
    .req(req), .load_pointer(load_pointer),
    .load_pointer_value(load_pointer_value), .rsp(rsp),
    .port_pin_in(pin_in), .port_alt_out_mask(alt_mask),
    .port_adr_out_mask(adr_mask), .port_latch_out(latch_out),
    .pointer_out(pointer_out), .protect_active(protect_active));

  // same register file built without the protection option
  brf_regfile #(.PROTECT_OPTION(1'b0)) dut_off (.clk_sys(clk_sys),
    .reset_n(reset_n), .clk_en(clk_en), .req(req),
    .load_pointer(load_pointer), .load_pointer_value(load_pointer_value),
    .rsp(rsp_off), .port_pin_in(pin_in), .port_alt_out_mask(alt_mask),
    .port_adr_out_mask(adr_mask), .port_latch_out(),
    .pointer_out(), .protect_active(protect_off));

  // execution unit model
  brf_core_model core (.clk_sys(clk_sys), .req(req),
    .load_pointer(load_pointer), .load_pointer_value(load_pointer_value),
    .rsp(rsp));

  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // compare and count
  task automatic ck(input string name, input logic [15:0] e,
    input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, e, g);
    end
  endtask

  // byte write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    core.access(1'b1, 1'b0, 1'b0, a, {8'h00, d});
  endtask

  // byte read with expected value
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    core.access(1'b0, 1'b0, 1'b0, a, 16'h0000);
    ck("answer strobe", 16'h0001, {15'h0000, core.last.valid});
    ck("byte read", {8'h00, e}, core.last.rdata);
  endtask

  // refusal flag of the latest access
  task automatic ckb(input logic e);
    ck("blocked", {15'h0000, e}, {15'h0000, core.last.blocked});
  endtask

  // verdict and end of run
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // hang guard, well beyond the few hundred cycles of the tests
  initial begin
    #200000;
    n_errors++;
    end_sim();
  end

  // test sequence
  initial begin
    n_errors = 0;
    num_checks = 0;
    reset_n = 1'b0;
    clk_en = 1'b1;
    for (int i = 0; i < 4; i++) begin
      pin_in[i] = 8'h5A;
      alt_mask[i] = 8'h00;
    end
    adr_mask[0] = 8'h00;
    adr_mask[1] = 8'h00;
    repeat (20) @(negedge clk_sys);
    reset_n = 1'b1;
    // location 0Fh of bank F written early after reset and read back
    core.load_ptr(8'h0F);
    wr(8'h0F, 8'h01);
    rd(8'h0F, 8'h01);
    core.load_ptr(8'h00);
    // control area: reset values, then write and read back
    for (int p = 0; p < 2; p++) begin
      for (int a = 240; a < 256; a++) begin
        wo = (a == 243) || (a >= 245 && a <= 249);
        exp_v = (p == 1 && a != 253) ? 8'h3C : 8'h00;
        rd(8'(a), wo ? 8'hFF : exp_v);
        if (p == 0 && a != 253) wr(8'(a), 8'h3C);
      end
    end
    // port reads and alternate-owned bits
    adr_mask[0] = 8'h0F;
    adr_mask[1] = 8'hC0;
    alt_mask[2] = 8'hF0;
    rd(8'h00, 8'h5F);
    rd(8'h01, 8'hDA);
    wr(8'h02, 8'h00);
    ck("port two latch", 16'h00F0, {8'h00, latch_out[2]});
    // word pair at an odd address
    core.access(1'b1, 1'b1, 1'b0, 8'h41, 16'hA55A);
    rd(8'h40, 8'hA5);
    rd(8'h41, 8'h5A);
    core.access(1'b0, 1'b1, 1'b0, 8'h41, 16'h0000);
    ck("word read", 16'hA55A, core.last.rdata);
    ck("word address", 16'h0040, {8'h00, core.last.padr});
    // working group 4 through the pointer
    core.load_ptr(8'h40);
    ck("pointer out", 16'h0040, {8'h00, pointer_out});
    rd(8'hFD, 8'h40);
    core.access(1'b0, 1'b0, 1'b1, 8'h01, 16'h0000);
    ck("short read", 16'h005A, core.last.rdata);
    ck("short address", 16'h0041, {8'h00, core.last.padr});
    rd(8'hE1, 8'h5A);
    ck("escape address", 16'h0041, {8'h00, core.last.padr});
    wr(8'h58, 8'hC3);
    rd(8'h58, 8'hC3);
    ck("direct address", 16'h0058, {8'h00, core.last.padr});
    // bank C replaces the low sixteen locations
    wr(8'h05, 8'h22);
    core.load_ptr(8'h4C);
    rd(8'hFD, 8'h4C);
    wr(8'h05, 8'h11);
    rd(8'h05, 8'h11);
    rd(8'h58, 8'hC3);
    core.load_ptr(8'h40);
    rd(8'h05, 8'h22);
    // upper area protection
    wr(8'h90, 8'h66);
    wr(8'h7F, 8'h44);
    wr(8'hFB, 8'h40);
    // protection state follows the mask one cycle later
    @(negedge clk_sys);
    ck("protect active", 16'h0001, {15'h0000, protect_active});
    ck("opt off active", 16'h0000, {15'h0000, protect_off});
    wr(8'h90, 8'h99);
    ckb(1'b1);
    ck("opt off blocked", 16'h0000, {15'h0000, rsp_off.blocked});
    rd(8'h80, 8'h00);
    ckb(1'b1);
    rd(8'h7F, 8'h44);
    ckb(1'b0);
    wr(8'hFB, 8'h00);
    @(negedge clk_sys);
    ck("protect off", 16'h0000, {15'h0000, protect_active});
    rd(8'h90, 8'h66);
    ck("opt off read", 16'h0099, rsp_off.rdata);
    // mid-run reset keeps general bytes, clears control
    @(negedge clk_sys);
    reset_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    reset_n = 1'b1;
    rd(8'h90, 8'h66);
    rd(8'h41, 8'h5A);
    rd(8'hFB, 8'h00);
    end_sim();
  end
endmodule // byte_register_file_decode_tb
`default_nettype wire
